// ---- pdc_cfg.svh ----
// Purpose: offsets, field positions, reset values and timing counts of the config bank
// Assumes: 8-bit registers, 7-bit serial address, sys_clk at 250 MHz
// Notes:   definitions only
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PDC_OFS_THRESHOLD    7'h0A
`define PDC_OFS_OFFLINE      7'h0B
`define PDC_OFS_SUPPLY       7'h0C
`define PDC_OFS_SHUNT        7'h0D

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PDC_RST_THRESHOLD    8'hDD
`define PDC_RST_OFFLINE      8'h00
`define PDC_RST_SUPPLY       8'h14
`define PDC_RST_SHUNT        8'h01

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PDC_HS_LVL_MSB       7
`define PDC_HS_LVL_LSB       4
`define PDC_LS_LVL_MSB       3
`define PDC_LS_LVL_LSB       0
`define PDC_DIAG_EN_BIT      4
`define PDC_PU1_BIT          3
`define PDC_PD1_BIT          2
`define PDC_PU2_BIT          1
`define PDC_PD2_BIT          0
`define PDC_UV_MODE_BIT      7
`define PDC_OV_MODE_MSB      6
`define PDC_OV_MODE_LSB      5
`define PDC_OV_DG_MSB        4
`define PDC_OV_DG_LSB        3
`define PDC_OV_LVL_BIT       2
`define PDC_CP_MODE_BIT      1
`define PDC_CP_LVL_BIT       0
`define PDC_SH_EN_BIT        7
`define PDC_BLK_SRC_BIT      6
`define PDC_BLK_MSB          5
`define PDC_BLK_LSB          3
`define PDC_DIV_BIT          2
`define PDC_GAIN_MSB         1
`define PDC_GAIN_LSB         0

// ----------------------------------------------------------------------
// serial frame and timing
// ----------------------------------------------------------------------
`define PDC_FRAME_BITS       5'd16
`define PDC_CMD_BITS         5'd8
`define PDC_CLK_MHZ          250
`define PDC_OV_DG_T0_NS      1000
`define PDC_OV_DG_T1_NS      2000
`define PDC_OV_DG_T2_NS      4000
`define PDC_OV_DG_T3_NS      8000
`define PDC_NS_TO_CYC(ns)    (((ns) * `PDC_CLK_MHZ) / 1000)

`endif

// ---- pdc_pkg.sv ----
// Purpose: shared types of the config bank
// Assumes: nothing beyond the cfg header
// Notes:   four registers, indexed 0..3 from the threshold register up
package pdc_pkg;
    typedef logic [7:0]   pdc_byte_type;
    typedef logic [1:0]   pdc_index_type;
    typedef logic [6:0]   pdc_addr_type;
    typedef pdc_byte_type pdc_regs_type [4];
    typedef enum logic [1:0]
    {
        PDC_ST_IDLE   = 2'b00,
        PDC_ST_SHIFT  = 2'b01,
        PDC_ST_COMMIT = 2'b10
    } pdc_state_type;
endpackage

// ---- pdc_bank_if.sv ----
// Purpose: carrier between serial engine and register storage
// Assumes: one clock domain
// Notes:   read data come back one cycle after rd_en
interface pdc_bank_if;
    import pdc_pkg::*;
    logic          wr_en;
    pdc_index_type wr_idx;
    pdc_byte_type  wr_data;
    logic          rd_en;
    logic          rd_hit;
    pdc_index_type rd_idx;
    pdc_byte_type  rd_data;
    pdc_regs_type  regs;
    modport ctrl (output wr_en, wr_idx, wr_data, rd_en, rd_hit, rd_idx,
                  input rd_data, regs);
    modport bank (input wr_en, wr_idx, wr_data, rd_en, rd_hit, rd_idx,
                  output rd_data, regs);
endinterface

// ---- pdc_reg_bank.sv ----
// Purpose: storage of the four configuration registers
// Assumes: writes and reads arrive already decoded
// Notes:   read data leave from a register; unmapped reads give zero
`include "pdc_cfg.svh"
module pdc_reg_bank
(
    input  wire logic   sys_clk,
    input  wire logic   rst,
    pdc_bank_if.bank    bus
);
    import pdc_pkg::*;

    localparam pdc_byte_type RST_VALUE [4] = '{`PDC_RST_THRESHOLD, `PDC_RST_OFFLINE,
                                               `PDC_RST_SUPPLY, `PDC_RST_SHUNT};

    // ----------------------------------------------------------------------
    // one byte per register, all bits writable
    // ----------------------------------------------------------------------
    for (genvar i = 0; i < 4; i++)
    begin : g_reg
        wire logic hit_wr = bus.wr_en && (bus.wr_idx == 2'(i));
        always_ff @(posedge sys_clk)
        begin
            if (rst)
                bus.regs[i] <= RST_VALUE[i];
            else if (hit_wr)
                bus.regs[i] <= bus.wr_data;
        end
    end

    // ----------------------------------------------------------------------
    // registered read port
    // ----------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            bus.rd_data <= 8'h00;
        else if (bus.rd_en)
            bus.rd_data <= bus.rd_hit ? bus.regs[bus.rd_idx] : 8'h00;
    end
endmodule // pdc_reg_bank

// ---- pdc_config_regs.sv ----
// Purpose: protection and diagnostic configuration bank behind the serial port
// Assumes: scs_n, sclk and sdi are synchronous to sys_clk; each sclk level
//          lasts at least 4 sys_clk cycles
// Notes:   16-bit frames, sclk idles low, sdi taken on the falling sclk edge,
//          sdo changed on the rising edge
//
// What this block does
// - threshold register resets to DDh, both trip fields at code 1101.
// - bits 7-4 pick one of sixteen high-side overcurrent trip levels.
// - bits 3-0 pick the low-side trip level, same code table.
// - offline diagnostic register resets to zero; reserved bits 7-5 writable.
// - bit 4 set puts monitors in real-time mode and enables sources.
// - bit 3 drives bridge 1 pull-up source, only with diagnostics enabled.
// - bit 2 drives bridge 1 pull-down source, only with diagnostics enabled.
// - bit 1 drives bridge 2 pull-up source, only with diagnostics enabled.
// - bit 0 drives bridge 2 pull-down source, only with diagnostics enabled.
// - supply monitor register resets to 14h.
// - bit 7 picks latched or auto-recover supply undervoltage handling.
// - bits 6-5 pick latch, recover, warn-only or off for supply overvoltage.
// - bits 4-3 set overvoltage deglitch of 1, 2, 4 or 8 us.
// - bit 2 picks overvoltage trip level, 21.5 V or 28.5 V.
// - bit 1 picks latched or auto-recover pump undervoltage handling.
// - bit 0 picks pump undervoltage level, 2.5 V or 5 V.
// - shunt amplifier register resets to 1h with the listed field layout.
// - gain field selects 10, 20, 40 or 80 V/V, resets to 01.
// - sample-and-hold bit off at 0, on at 1, resets to 0.
// - blanking source bit picks half-bridge 1 or half-bridge 2.
// - reference divider bit picks half or one eighth of the reference.
`include "pdc_cfg.svh"
module pdc_config_regs
(
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         scs_n,
    input  wire logic         sclk,
    input  wire logic         sdi,
    output logic              sdo,
    output logic              sdo_oe,
    output logic [3:0]        high_side_trip_level,
    output logic [3:0]        low_side_trip_level,
    output logic              offline_diag_enable,
    output logic              drain_monitor_realtime,
    output logic              bridge1_pullup_source,
    output logic              bridge1_pulldown_source,
    output logic              bridge2_pullup_source,
    output logic              bridge2_pulldown_source,
    output logic              supply_under_mode,
    output logic [1:0]        supply_over_mode,
    output logic              supply_over_latched,
    output logic              supply_over_auto,
    output logic              supply_over_warn_only,
    output logic              supply_over_disabled,
    output logic [1:0]        supply_over_deglitch,
    output logic [10:0]       supply_over_deglitch_cycles,
    output logic              supply_over_level,
    output logic              pump_under_mode,
    output logic              pump_under_level,
    output logic              amp_sample_hold_enable,
    output logic              amp_blank_source,
    output logic [2:0]        amp_blank_time,
    output logic              amp_reference_divider,
    output logic [1:0]        amp_gain_select
);
    import pdc_pkg::*;

    // ----------------------------------------------------------------------
    // deglitch times as sys_clk counts
    // ----------------------------------------------------------------------
    localparam logic [10:0] OV_DG_CYC0 = 11'(`PDC_NS_TO_CYC(`PDC_OV_DG_T0_NS));
    localparam logic [10:0] OV_DG_CYC1 = 11'(`PDC_NS_TO_CYC(`PDC_OV_DG_T1_NS));
    localparam logic [10:0] OV_DG_CYC2 = 11'(`PDC_NS_TO_CYC(`PDC_OV_DG_T2_NS));
    localparam logic [10:0] OV_DG_CYC3 = 11'(`PDC_NS_TO_CYC(`PDC_OV_DG_T3_NS));

    pdc_bank_if bank_bus ();

    pdc_reg_bank u_bank
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .bus     (bank_bus.bank)
    );

    // ----------------------------------------------------------------------
    // serial pin edge detection
    // ----------------------------------------------------------------------
    logic          sclk_q;
    logic          scs_n_q;
    wire logic     frame_open   = ~scs_n;
    wire logic     frame_start  = ~scs_n & scs_n_q;
    wire logic     frame_end    = scs_n & ~scs_n_q;
    wire logic     sclk_rise    = frame_open & sclk & ~sclk_q;
    wire logic     sclk_fall    = frame_open & ~sclk & sclk_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sclk_q  <= 1'b0;
            scs_n_q <= 1'b1;
        end
        else
        begin
            sclk_q  <= sclk;
            scs_n_q <= scs_n;
        end
    end

    // ----------------------------------------------------------------------
    // frame state machine
    // ----------------------------------------------------------------------
    pdc_state_type state;
    pdc_state_type next_state;
    logic [4:0]    bit_cnt;
    logic [15:0]   rx_word;

    // more than sixteen bits saturates the count, so an overlong frame is refused
    wire logic     cnt_full     = (bit_cnt == `PDC_FRAME_BITS + 5'd1);
    wire logic     frame_ok     = (bit_cnt == `PDC_FRAME_BITS);
    wire logic     is_read      = rx_word[15];
    wire pdc_addr_type cmd_addr = rx_word[14:8];

    always_comb
    begin
        next_state = state;
        case (state)
            PDC_ST_IDLE:
                if (frame_start)
                    next_state = PDC_ST_SHIFT;
            PDC_ST_SHIFT:
                if (frame_end)
                    next_state = frame_ok ? PDC_ST_COMMIT : PDC_ST_IDLE;
            PDC_ST_COMMIT:
                next_state = PDC_ST_IDLE;
            default:
                next_state = PDC_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state <= PDC_ST_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bit_cnt <= 5'd0;
            rx_word <= 16'h0000;
        end
        else if (frame_start)
        begin
            bit_cnt <= 5'd0;
            rx_word <= 16'h0000;
        end
        else if (state == PDC_ST_SHIFT && sclk_fall && !cnt_full)
        begin
            bit_cnt <= bit_cnt + 5'd1;
            rx_word <= {rx_word[14:0], sdi};
        end
    end

    // ----------------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------------
    function automatic logic map_hit(input pdc_addr_type a);
        map_hit = (a >= `PDC_OFS_THRESHOLD) && (a <= `PDC_OFS_SHUNT);
    endfunction

    function automatic pdc_index_type map_idx(input pdc_addr_type a);
        pdc_addr_type d;
        d = a - `PDC_OFS_THRESHOLD;
        map_idx = d[1:0];
    endfunction

    // after the eighth bit the command byte sits in the low byte of rx_word
    wire pdc_addr_type rd_addr  = rx_word[6:0];
    wire logic     cmd_done     = (bit_cnt == `PDC_CMD_BITS);
    logic          cmd_seen;
    logic          rd_pending;
    logic          rd_valid;

    always_ff @(posedge sys_clk)
    begin
        if (rst || frame_start)
            cmd_seen <= 1'b0;
        else if (cmd_done)
            cmd_seen <= 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rd_pending <= 1'b0;
            rd_valid   <= 1'b0;
        end
        else
        begin
            rd_pending <= cmd_done && !cmd_seen;
            rd_valid   <= rd_pending;
        end
    end

    // ----------------------------------------------------------------------
    // bank access: reads fetch the old value, writes land at frame end
    // ----------------------------------------------------------------------
    assign bank_bus.rd_en   = rd_pending;
    assign bank_bus.rd_hit  = map_hit(rd_addr);
    assign bank_bus.rd_idx  = map_idx(rd_addr);
    // a short or long frame never reaches COMMIT, so nothing is written
    assign bank_bus.wr_en   = (state == PDC_ST_COMMIT) && !is_read && map_hit(cmd_addr);
    assign bank_bus.wr_idx  = map_idx(cmd_addr);
    assign bank_bus.wr_data = rx_word[7:0];   // reserved bits stored as written

    // ----------------------------------------------------------------------
    // serial output
    // ----------------------------------------------------------------------
    pdc_byte_type  tx_byte;

    always_ff @(posedge sys_clk)
    begin
        if (rst || frame_start)
            tx_byte <= 8'h00;
        else if (rd_valid)
            tx_byte <= bank_bus.rd_data;
        else if (sclk_rise && cmd_seen)
            tx_byte <= {tx_byte[6:0], 1'b0};
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst || !frame_open)
            sdo <= 1'b0;
        else if (sclk_rise)
            sdo <= cmd_seen ? tx_byte[7] : 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            sdo_oe <= 1'b0;
        else
            sdo_oe <= frame_open;
    end

    // ----------------------------------------------------------------------
    // field decode
    // ----------------------------------------------------------------------
    wire pdc_byte_type reg_thr  = bank_bus.regs[0];
    wire pdc_byte_type reg_off  = bank_bus.regs[1];
    wire pdc_byte_type reg_sup  = bank_bus.regs[2];
    wire pdc_byte_type reg_amp  = bank_bus.regs[3];

    wire logic       diag_on    = reg_off[`PDC_DIAG_EN_BIT];
    // sources are forced off while diagnostics are disabled
    wire logic [3:0] src_req    = reg_off[3:0];
    wire logic [3:0] src_gated  = src_req & {4{diag_on}};
    wire logic [1:0] ov_mode    = reg_sup[`PDC_OV_MODE_MSB:`PDC_OV_MODE_LSB];
    wire logic [1:0] ov_dg      = reg_sup[`PDC_OV_DG_MSB:`PDC_OV_DG_LSB];
    logic [10:0]     ov_dg_cyc;

    always_comb
    begin
        case (ov_dg)
            2'b00:   ov_dg_cyc = OV_DG_CYC0;
            2'b01:   ov_dg_cyc = OV_DG_CYC1;
            2'b10:   ov_dg_cyc = OV_DG_CYC2;
            2'b11:   ov_dg_cyc = OV_DG_CYC3;
            default: ov_dg_cyc = OV_DG_CYC2;
        endcase
    end

    // ----------------------------------------------------------------------
    // registered configuration outputs
    // ----------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            high_side_trip_level <= 4'hD;
            low_side_trip_level  <= 4'hD;
        end
        else
        begin
            high_side_trip_level <= reg_thr[`PDC_HS_LVL_MSB:`PDC_HS_LVL_LSB];
            low_side_trip_level  <= reg_thr[`PDC_LS_LVL_MSB:`PDC_LS_LVL_LSB];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            offline_diag_enable     <= 1'b0;
            drain_monitor_realtime  <= 1'b0;
            bridge1_pullup_source   <= 1'b0;
            bridge1_pulldown_source <= 1'b0;
            bridge2_pullup_source   <= 1'b0;
            bridge2_pulldown_source <= 1'b0;
        end
        else
        begin
            offline_diag_enable     <= diag_on;
            drain_monitor_realtime  <= diag_on;
            bridge1_pullup_source   <= src_gated[`PDC_PU1_BIT];
            bridge1_pulldown_source <= src_gated[`PDC_PD1_BIT];
            bridge2_pullup_source   <= src_gated[`PDC_PU2_BIT];
            bridge2_pulldown_source <= src_gated[`PDC_PD2_BIT];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            supply_under_mode           <= 1'b0;
            supply_over_mode            <= 2'b00;
            supply_over_latched         <= 1'b1;
            supply_over_auto            <= 1'b0;
            supply_over_warn_only       <= 1'b0;
            supply_over_disabled        <= 1'b0;
            supply_over_deglitch        <= 2'b10;
            supply_over_deglitch_cycles <= OV_DG_CYC2;
            supply_over_level           <= 1'b1;
            pump_under_mode             <= 1'b0;
            pump_under_level            <= 1'b0;
        end
        else
        begin
            supply_under_mode           <= reg_sup[`PDC_UV_MODE_BIT];
            supply_over_mode            <= ov_mode;
            supply_over_latched         <= (ov_mode == 2'b00);
            supply_over_auto            <= (ov_mode == 2'b01);
            supply_over_warn_only       <= (ov_mode == 2'b10);
            supply_over_disabled        <= (ov_mode == 2'b11);
            supply_over_deglitch        <= ov_dg;
            supply_over_deglitch_cycles <= ov_dg_cyc;
            supply_over_level           <= reg_sup[`PDC_OV_LVL_BIT];
            pump_under_mode             <= reg_sup[`PDC_CP_MODE_BIT];
            pump_under_level            <= reg_sup[`PDC_CP_LVL_BIT];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            amp_sample_hold_enable <= 1'b0;
            amp_blank_source       <= 1'b0;
            amp_blank_time         <= 3'h0;
            amp_reference_divider  <= 1'b0;
            amp_gain_select        <= 2'b01;
        end
        else
        begin
            amp_sample_hold_enable <= reg_amp[`PDC_SH_EN_BIT];
            amp_blank_source       <= reg_amp[`PDC_BLK_SRC_BIT];
            amp_blank_time         <= reg_amp[`PDC_BLK_MSB:`PDC_BLK_LSB];
            amp_reference_divider  <= reg_amp[`PDC_DIV_BIT];
            amp_gain_select        <= reg_amp[`PDC_GAIN_MSB:`PDC_GAIN_LSB];
        end
    end
endmodule // pdc_config_regs

// ---- pdc_config_regs_asserts.sv ----
// Purpose: port-level checks of the config bank
// Assumes: synchronous active-high reset held at least two cycles
// Notes:   bound to pdc_config_regs below the module
module pdc_config_regs_asserts
(
    input logic        sys_clk,
    input logic        rst,
    input logic        sdo,
    input logic        sdo_oe,
    input logic [3:0]  high_side_trip_level,
    input logic [3:0]  low_side_trip_level,
    input logic        offline_diag_enable,
    input logic        drain_monitor_realtime,
    input logic        bridge1_pullup_source,
    input logic        bridge1_pulldown_source,
    input logic        bridge2_pullup_source,
    input logic        bridge2_pulldown_source,
    input logic [1:0]  supply_over_mode,
    input logic        supply_over_latched,
    input logic        supply_over_auto,
    input logic        supply_over_warn_only,
    input logic        supply_over_disabled,
    input logic [1:0]  supply_over_deglitch,
    input logic [10:0] supply_over_deglitch_cycles,
    input logic        supply_over_level,
    input logic        amp_sample_hold_enable,
    input logic [1:0]  amp_gain_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ----
    // checks
    // ----
    property p_pu1_gate;
        bridge1_pullup_source |-> offline_diag_enable;
    endproperty
    a_pu1_gate: assert property (p_pu1_gate)
        else $error("pu1 ungated");
    property p_pd1_gate;
        bridge1_pulldown_source |-> offline_diag_enable;
    endproperty
    a_pd1_gate: assert property (p_pd1_gate)
        else $error("pd1 ungated");
    property p_pu2_gate;
        bridge2_pullup_source |-> offline_diag_enable;
    endproperty
    a_pu2_gate: assert property (p_pu2_gate)
        else $error("pu2 ungated");
    property p_pd2_gate;
        bridge2_pulldown_source |-> offline_diag_enable;
    endproperty
    a_pd2_gate: assert property (p_pd2_gate)
        else $error("pd2 ungated");
    property p_realtime;
        drain_monitor_realtime == offline_diag_enable;
    endproperty
    a_realtime: assert property (p_realtime)
        else $error("realtime mismatch");
    property p_ov_decode;
        {supply_over_disabled, supply_over_warn_only, supply_over_auto, supply_over_latched}
            == 4'h1 << supply_over_mode;
    endproperty
    a_ov_decode: assert property (p_ov_decode)
        else $error("ov decode");
    property p_deglitch;
        supply_over_deglitch_cycles == (11'd250 << supply_over_deglitch);
    endproperty
    a_deglitch: assert property (p_deglitch)
        else $error("deglitch count");
    // reset checks run during reset, so no disable
    property p_rst_thr;
        disable iff (1'b0) rst [*2] |=> high_side_trip_level == 4'hD && low_side_trip_level == 4'hD;
    endproperty
    a_rst_thr: assert property (p_rst_thr)
        else $error("trip reset");
    property p_rst_diag;
        disable iff (1'b0) rst [*2] |=> !offline_diag_enable && !bridge1_pullup_source;
    endproperty
    a_rst_diag: assert property (p_rst_diag)
        else $error("diag reset");
    property p_rst_sup;
        disable iff (1'b0) rst [*2] |=> supply_over_mode == 2'b00 && supply_over_deglitch ==
        2'b10 && supply_over_level;
    endproperty
    a_rst_sup: assert property (p_rst_sup)
        else $error("supply reset");
    property p_rst_amp;
        disable iff (1'b0) rst [*2] |=> amp_gain_select == 2'b01 && !amp_sample_hold_enable;
    endproperty
    a_rst_amp: assert property (p_rst_amp)
        else $error("amp reset");
    property p_sdo_idle;
        !sdo_oe |-> !sdo;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle)
        else $error("sdo idle");
endmodule // pdc_config_regs_asserts
bind pdc_config_regs pdc_config_regs_asserts u_chk (.*);

// ---- pdc_host_model.sv ----
// Purpose: host side of the serial config link
// Assumes: 16-bit frames, sclk idles low, device takes sdi on sclk fall
// Notes:   every change lands on the falling sys_clk edge
module pdc_host_model
(
    input  wire logic  sys_clk,
    input  wire logic  sdo,
    input  wire logic  sdo_oe,
    output logic       scs_n,
    output logic       sclk,
    output logic       sdi,
    output logic       rd_valid,
    output logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        scs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end
    task automatic frame(input logic [15:0] f, input int n);
        logic [7:0] got;
        logic       last;
        got = 8'h00;
        last = 1'b0;
        scs_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        for (int i = 0; i < n; i++)
        begin
            sdi = f[15 - i];
            sclk = 1'b1;
            repeat (4) @(negedge sys_clk);
            // undriven sdo reads as the inverse of the last level
            last = sdo_oe ? sdo : ~last;
            got = {got[6:0], last};
            sclk = 1'b0;
            repeat (4) @(negedge sys_clk);
        end
        scs_n = 1'b1;
        rd_data = got;
        rd_valid = f[15] && n == 16;
        @(negedge sys_clk);
        rd_valid = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask
endmodule // pdc_host_model

// ---- pdc_config_regs_tb.sv ----
// Purpose: self-checking bench of the config bank
// Assumes: host model drives the serial link at the falling edge
// Notes:   reads queue expected bytes for the monitor
module pdc_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 40000;
    logic            sys_clk;
    logic            rst;
    wire logic       scs_n, sclk, sdi, sdo, sdo_oe, rd_valid;
    wire logic [7:0] rd_data, o_thr, o_sup, o_amp;
    wire logic [4:0] o_src;
    logic [7:0]      exp_reg [4];
    logic [7:0]      q [$];
    logic [15:0]     lfsr;
    int              failures = 0, checks = 0, cycles = 0;
    pdc_config_regs uut
    (
        .sys_clk(sys_clk), .rst(rst), .scs_n(scs_n), .sclk(sclk), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe),
        .high_side_trip_level(o_thr[7:4]), .low_side_trip_level(o_thr[3:0]),
        .offline_diag_enable(o_src[4]), .drain_monitor_realtime(),
        .bridge1_pullup_source(o_src[3]), .bridge1_pulldown_source(o_src[2]),
        .bridge2_pullup_source(o_src[1]), .bridge2_pulldown_source(o_src[0]),
        .supply_under_mode(o_sup[7]), .supply_over_mode(o_sup[6:5]),
        .supply_over_latched(), .supply_over_auto(), .supply_over_warn_only(),
        .supply_over_disabled(), .supply_over_deglitch(o_sup[4:3]),
        .supply_over_deglitch_cycles(), .supply_over_level(o_sup[2]),
        .pump_under_mode(o_sup[1]), .pump_under_level(o_sup[0]),
        .amp_sample_hold_enable(o_amp[7]), .amp_blank_source(o_amp[6]),
        .amp_blank_time(o_amp[5:3]), .amp_reference_divider(o_amp[2]),
        .amp_gain_select(o_amp[1:0])
    );
    pdc_host_model u_host
    (
        .sys_clk(sys_clk), .sdo(sdo), .sdo_oe(sdo_oe), .scs_n(scs_n),
        .sclk(sclk), .sdi(sdi), .rd_valid(rd_valid), .rd_data(rd_data)
    );
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // ----
    // tasks
    // ----
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
        u_host.frame({1'b0, a, d}, n);
        if (n == 16 && a >= 7'h0A && a <= 7'h0D)
            exp_reg[2'(a - 7'h0A)] = d;
    endtask
    task automatic rd(input logic [6:0] a);
        q.push_back((a >= 7'h0A && a <= 7'h0D) ? exp_reg[2'(a - 7'h0A)] : 8'h00);
        u_host.frame({1'b1, a, 8'h00}, 16);
    endtask
    task automatic check_all(input string name);
        for (int i = 0; i < 4; i++)
            rd(7'h0A + 7'(i));
        cmp_byte("thresholds", exp_reg[0], o_thr);
        cmp_byte("diag", {3'b000, exp_reg[1][4], exp_reg[1][3:0]
            & {4{exp_reg[1][4]}}}, {3'b000, o_src});
        cmp_byte("supply", exp_reg[2], o_sup);
        cmp_byte("amp", exp_reg[3], o_amp);
        $display("test %s done", name);
    endtask
    task automatic do_reset();
        rst = 1'b1;
        exp_reg = '{8'hDD, 8'h00, 8'h14, 8'h01};
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
    endtask
    always @(posedge sys_clk)
    begin
        if (rd_valid === 1'b1)
            cmp_byte("read data", q.pop_front(), rd_data);
        cycles++;
        if (cycles == LIMIT)
        begin
            failures++;
            report_and_stop();
        end
    end
    // ----
    // main sequence
    // ----
    initial
    begin
        lfsr = 16'hA1CF;
        do_reset();
        check_all("reset");
        for (int i = 0; i < 16; i++)
        begin
            lfsr = next_rand(lfsr);
            wr(7'h0A, {i[3:0], ~i[3:0]}, 16);
            wr(7'h0B, {3'b000, i[0], lfsr[3:0]}, 16);
            wr(7'h0C, {lfsr[15], i[1:0], i[3:2], lfsr[10:8]}, 16);
            wr(7'h0D, {lfsr[14:9], i[1:0]}, 16);
            check_all("sweep");
        end
        wr(7'h0A, 8'h5A, 15);
        wr(7'h0E, 8'hFF, 16);
        rd(7'h0E);
        rd(7'h09);
        check_all("refused");
        do_reset();
        check_all("second reset");
        wr(7'h0B, 8'h1F, 16);
        check_all("walk");
        report_and_stop();
    end
endmodule // pdc_config_regs_tb
